// ### inc/hppd_defs.vh
`ifndef HPPD_DEFS_VH
`define HPPD_DEFS_VH

// ---------------------------------------------------------------
// apb register byte offsets
// ---------------------------------------------------------------
`define HPPD_OFS_IFCTRL   8'h00
`define HPPD_OFS_CMD      8'h04
`define HPPD_OFS_STATUS   8'h08
`define HPPD_OFS_DIN      8'h0c
`define HPPD_OFS_DOUT     8'h10
`define HPPD_OFS_IRQSET   8'h14
`define HPPD_OFS_FLAG     8'h18

// ---------------------------------------------------------------
// iface_control_reg fields
// ---------------------------------------------------------------
`define HPPD_IFC_POL      0
`define HPPD_IFC_ENDIAN   1
`define HPPD_IFC_SIZE     2
`define HPPD_IFC_DONE     3
`define HPPD_IFC_MODE_LO  4
`define HPPD_IFC_MODE_HI  5

// ---------------------------------------------------------------
// flag port bits
// ---------------------------------------------------------------
`define HPPD_FLG_RQI      0
`define HPPD_FLG_DVI      1
`define HPPD_FLG_CMDP     2
`define HPPD_FLG_DINF     3

// ---------------------------------------------------------------
// host address decode and strobe modes
// ---------------------------------------------------------------
`define HPPD_HA_FLAG      2
`define HPPD_HA_DATA      1
`define HPPD_HA_BYTE      0
`define HPPD_MODE_SEP     2'h0
`define HPPD_MODE_LANE    2'h1
`define HPPD_MODE_DS_RW   2'h2
`define HPPD_SEL_LANE     3'h1
`define HPPD_SEL_DS_RW    3'h2

// ---------------------------------------------------------------
// reset values
// ---------------------------------------------------------------
`define HPPD_RST_W16      16'h0000
`define HPPD_RST_W32      32'h0000_0000
`define HPPD_RST_IFC      6'h00

`endif

// ### core/hppd_port.v
// The implementer's own choices: the APB interface to the registers and the address map.
`timescale 1ns/1ps
// Operation
// - chip select low enables strobes; else ignored
// - addr 00x: write command, read status
// - addr 01x: data port read and write
// - addr 1xx: read-only flag port
// - 8-bit: addr bit0 picks byte; 16-bit ignores
// - 8-bit mode never drives upper data lines
// - raise irq; host reads flags for cause
// - polarity strap sets irq active level
// - endian strap swaps command/status bytes
// - size strap: 1 is 8-bit, 0 16-bit
// - straps captured into control reg on the first clock after reset
// - strobe meaning follows interface select inputs
`include "hppd_defs.vh"

module hppd_port (
    input wire pclk,
    input wire presetn,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [7:0] paddr,
    input wire [31:0] pwdata,
    output reg [31:0] prdata,
    output wire pready,
    output wire pslverr,
    input wire host_chip_select_n,
    input wire [2:0] host_port_addr,
    input wire [15:0] host_data_bus_in,
    output reg [15:0] host_data_bus_out,
    output wire [1:0] host_data_bus_oe,
    input wire host_read_strobe0_n,
    input wire host_read_strobe1_n,
    input wire host_write_strobe0_n,
    input wire host_write_strobe1_n,
    output wire host_irq_out,
    output wire host_irq_oe,
    input wire [2:0] iface_type_select,
    input wire irq_polarity_strap,
    input wire byte_order_strap,
    input wire bus_size_strap
);

    // ---------------------------------------------------------------
    // strap capture
    // ---------------------------------------------------------------
    // async reset loads constants only; straps are taken on the first
    // clock after release, so the control register never sees a pin
    // through the reset path
    reg [5:0] iface_control_reg;
    wire ifc_pol = iface_control_reg[`HPPD_IFC_POL];
    wire ifc_big = iface_control_reg[`HPPD_IFC_ENDIAN];
    wire ifc_8b = iface_control_reg[`HPPD_IFC_SIZE];
    wire ifc_done = iface_control_reg[`HPPD_IFC_DONE];
    wire [1:0] ifc_mode = iface_control_reg[`HPPD_IFC_MODE_HI:`HPPD_IFC_MODE_LO];
    reg [1:0] mode_dec;

    always @* begin
        if (iface_type_select == `HPPD_SEL_LANE) begin
            mode_dec = `HPPD_MODE_LANE;
        end else if (iface_type_select == `HPPD_SEL_DS_RW) begin
            mode_dec = `HPPD_MODE_DS_RW;
        end else begin
            mode_dec = `HPPD_MODE_SEP;
        end
    end

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            iface_control_reg <= `HPPD_RST_IFC;
        end else if (!ifc_done) begin
            iface_control_reg <= {mode_dec, 1'b1, bus_size_strap, byte_order_strap, irq_polarity_strap};
        end
    end

    // ---------------------------------------------------------------
    // strobe interpretation
    // ---------------------------------------------------------------
    reg rd_act;
    reg wr_act;
    reg [1:0] lane_16;
    wire cs_act = ~host_chip_select_n & ifc_done;
    // the strobes mean nothing until the interface mode is captured, and a
    // read wins when both directions look active in one cycle

    always @* begin
        lane_16 = 2'b11;
        rd_act = 1'b0;
        wr_act = 1'b0;
        case (ifc_mode)
            `HPPD_MODE_LANE: begin
                rd_act = ~host_read_strobe0_n | ~host_read_strobe1_n;
                wr_act = ~host_write_strobe0_n | ~host_write_strobe1_n;
                lane_16 = rd_act ? {~host_read_strobe1_n, ~host_read_strobe0_n}
                                 : {~host_write_strobe1_n, ~host_write_strobe0_n};
            end
            `HPPD_MODE_DS_RW: begin
                rd_act = ~host_read_strobe0_n & host_write_strobe0_n;
                wr_act = ~host_read_strobe0_n & ~host_write_strobe0_n;
            end
            default: begin
                rd_act = ~host_read_strobe0_n;
                wr_act = ~host_write_strobe0_n;
            end
        endcase
        rd_act = rd_act & cs_act;
        wr_act = wr_act & cs_act & ~rd_act;
    end

    reg rd_q_r;
    reg wr_q_r;
    wire rd_start = rd_act & ~rd_q_r;
    wire wr_start = wr_act & ~wr_q_r;

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rd_q_r <= 1'b0;
            wr_q_r <= 1'b0;
        end else begin
            rd_q_r <= rd_act;
            wr_q_r <= wr_act;
        end
    end

    // ---------------------------------------------------------------
    // port decode
    // ---------------------------------------------------------------
    wire sel_flag = host_port_addr[`HPPD_HA_FLAG];
    wire sel_data = ~sel_flag & host_port_addr[`HPPD_HA_DATA];
    wire sel_cmd = ~sel_flag & ~host_port_addr[`HPPD_HA_DATA];
    // in 8-bit mode the byte bit picks a half; big endian flips it on the
    // command/status port only
    wire byte_hi = host_port_addr[`HPPD_HA_BYTE] ^ (sel_cmd & ifc_big);
    wire [1:0] lane = ifc_8b ? {byte_hi, ~byte_hi} : lane_16;
    wire word_done = ifc_8b ? host_port_addr[`HPPD_HA_BYTE] : 1'b1;
    wire [15:0] hin_sw = (sel_cmd & ifc_big & ~ifc_8b) ?
                         {host_data_bus_in[7:0], host_data_bus_in[15:8]} : host_data_bus_in;
    wire [15:0] hin = ifc_8b ? {host_data_bus_in[7:0], host_data_bus_in[7:0]} : hin_sw;

    // ---------------------------------------------------------------
    // port storage and flags
    // ---------------------------------------------------------------
    wire [15:0] cmd_r;
    reg [15:0] status_r;
    wire [15:0] din_r;
    reg [15:0] dout_r;
    reg rqi_r;
    reg dvi_r;
    reg cmdp_r;
    reg dinf_r;
    wire [15:0] flag_word = {12'h000, dinf_r, cmdp_r, dvi_r, rqi_r};

    wire apb_wr = psel & penable & pwrite;
    wire apb_rd = psel & penable & ~pwrite;
    wire host_cmd_wr = wr_start & sel_cmd;
    wire host_din_wr = wr_start & sel_data;
    wire host_flag_rd = rd_start & sel_flag;
    wire host_dout_rd = rd_start & sel_data & word_done;
    wire cpu_rqi_set = apb_wr & (paddr == `HPPD_OFS_IRQSET) & pwdata[`HPPD_FLG_RQI];
    wire cpu_dvi_set = apb_wr & (paddr == `HPPD_OFS_DOUT);
    wire cpu_cmd_rd = apb_rd & (paddr == `HPPD_OFS_CMD);
    wire cpu_din_rd = apb_rd & (paddr == `HPPD_OFS_DIN);
    wire [1:0] we_lane = lane;

    genvar gi;
    generate
        for (gi = 0; gi < 2; gi = gi + 1) begin : g_lane
            reg [7:0] cmd_lane_r;
            reg [7:0] din_lane_r;
            // one flop set per byte lane keeps every lane on a single driver
            always @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    cmd_lane_r <= 8'h00;
                    din_lane_r <= 8'h00;
                end else begin
                    if (host_cmd_wr && we_lane[gi]) begin
                        cmd_lane_r <= hin[gi*8 +: 8];
                    end
                    if (host_din_wr && we_lane[gi]) begin
                        din_lane_r <= hin[gi*8 +: 8];
                    end
                end
            end
            assign cmd_r[gi*8 +: 8] = cmd_lane_r;
            assign din_r[gi*8 +: 8] = din_lane_r;
        end
    endgenerate

    // every flag: hardware set wins over a clear in the same cycle
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            status_r <= `HPPD_RST_W16;
            dout_r <= `HPPD_RST_W16;
            rqi_r <= 1'b0;
            dvi_r <= 1'b0;
            cmdp_r <= 1'b0;
            dinf_r <= 1'b0;
        end else begin
            if (apb_wr && paddr == `HPPD_OFS_STATUS) begin
                status_r <= pwdata[15:0];
            end
            if (cpu_dvi_set) begin
                dout_r <= pwdata[15:0];
            end
            if (cpu_rqi_set) begin
                rqi_r <= 1'b1;
            end else if (host_flag_rd) begin
                rqi_r <= 1'b0;
            end
            if (cpu_dvi_set) begin
                dvi_r <= 1'b1;
            end else if (host_dout_rd) begin
                dvi_r <= 1'b0;
            end
            if (host_cmd_wr && word_done) begin
                cmdp_r <= 1'b1;
            end else if (cpu_cmd_rd) begin
                cmdp_r <= 1'b0;
            end
            if (host_din_wr && word_done) begin
                dinf_r <= 1'b1;
            end else if (cpu_din_rd) begin
                dinf_r <= 1'b0;
            end
        end
    end

    // ---------------------------------------------------------------
    // host read path
    // ---------------------------------------------------------------
    reg [15:0] rd_word;
    always @* begin
        if (sel_flag) begin
            rd_word = flag_word;
        end else if (sel_data) begin
            rd_word = dout_r;
        end else if (ifc_big && !ifc_8b) begin
            rd_word = {status_r[7:0], status_r[15:8]};
        end else begin
            rd_word = status_r;
        end
    end

    // data out is registered and loaded once, when the strobe is first seen:
    // a flag read clears its cause on that edge, so a reload would hand the
    // host the cleared value; the host's access time must cover one clock
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            host_data_bus_out <= `HPPD_RST_W16;
        end else if (rd_start) begin
            if (ifc_8b) begin
                host_data_bus_out <= {8'h00, byte_hi ? rd_word[15:8] : rd_word[7:0]};
            end else begin
                host_data_bus_out <= rd_word;
            end
        end
    end

    assign host_data_bus_oe = {rd_act & rd_q_r & ~ifc_8b & lane[1], rd_act & rd_q_r & (ifc_8b | lane[0])};

    // ---------------------------------------------------------------
    // interrupt
    // ---------------------------------------------------------------
    // driven at both levels once the straps are in; the board pull only
    // holds the line while reset keeps the output off
    wire irq_any = rqi_r | dvi_r;
    assign host_irq_out = ifc_pol ? irq_any : ~irq_any;
    assign host_irq_oe = ifc_done;

    // ---------------------------------------------------------------
    // apb slave
    // ---------------------------------------------------------------
    // zero wait states; an unmapped offset answers with an error and reads
    // zero, and writes to read-only offsets are dropped
    reg hit;
    always @* begin
        hit = 1'b1;
        prdata = `HPPD_RST_W32;
        if (paddr == `HPPD_OFS_IFCTRL) begin
            prdata = {26'h0000000, iface_control_reg};
        end else if (paddr == `HPPD_OFS_CMD) begin
            prdata = {16'h0000, cmd_r};
        end else if (paddr == `HPPD_OFS_STATUS) begin
            prdata = {16'h0000, status_r};
        end else if (paddr == `HPPD_OFS_DIN) begin
            prdata = {16'h0000, din_r};
        end else if (paddr == `HPPD_OFS_DOUT) begin
            prdata = {16'h0000, dout_r};
        end else if (paddr == `HPPD_OFS_IRQSET) begin
            prdata = `HPPD_RST_W32;
        end else if (paddr == `HPPD_OFS_FLAG) begin
            prdata = {16'h0000, flag_word};
        end else begin
            hit = 1'b0;
        end
    end

    assign pready = 1'b1;
    assign pslverr = psel & penable & ~hit;

endmodule

// ### testbench/hppd_port_checker.sv
`timescale 1ns/1ps
// --------------------------------
// host port checker
// --------------------------------
module hppd_port_checker (
    input wire pclk,
    input wire presetn,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [7:0] paddr,
    input wire [31:0] prdata,
    input wire host_chip_select_n,
    input wire [1:0] host_data_bus_oe,
    input wire host_read_strobe0_n,
    input wire host_read_strobe1_n,
    input wire host_write_strobe0_n,
    input wire host_irq_out,
    input wire host_irq_oe,
    input wire [2:0] iface_type_select,
    input wire irq_polarity_strap,
    input wire byte_order_strap,
    input wire bus_size_strap
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    a_cs_quiet: assert property (host_chip_select_n |-> host_data_bus_oe == 2'b00)
        else $error("lines driven without chip select");
    a_upper_idle: assert property (bus_size_strap |-> !host_data_bus_oe[1])
        else $error("upper lines driven in byte mode");
    a_no_read: assert property (host_read_strobe0_n && host_read_strobe1_n |-> host_data_bus_oe == 2'b00)
        else $error("lines driven without read strobe");
    a_rd_answer: assert property (
        $fell(host_read_strobe0_n) && host_write_strobe0_n && !host_chip_select_n
        ##1 !host_read_strobe0_n && !host_chip_select_n |-> host_data_bus_oe[0])
        else $error("read answer missing");
    a_dsrw_write: assert property (
        iface_type_select == 3'h2 && !host_write_strobe0_n |-> host_data_bus_oe == 2'b00)
        else $error("write taken as read");
    a_wide_read: assert property (
        !bus_size_strap && iface_type_select != 3'h1 && host_data_bus_oe[0] |-> host_data_bus_oe[1])
        else $error("wide read drives one lane");
    a_irq_level: assert property (
        psel && penable && pwrite && paddr == 8'h10 |=> host_irq_out == irq_polarity_strap)
        else $error("irq level wrong");
    a_irq_drive: assert property (presetn |=> host_irq_oe)
        else $error("irq line not driven");
    a_strap_copy: assert property (
        psel && penable && !pwrite && paddr == 8'h00
        |-> prdata[3:0] == {1'b1, bus_size_strap, byte_order_strap, irq_polarity_strap})
        else $error("strap copy wrong");
endmodule

// ### testbench/hppd_host_model.sv
`timescale 1ns/1ps
// --------------------------------
// host processor model
// --------------------------------
module hppd_host_model (
    input wire pclk,
    input wire [2:0] iface_type_select,
    input wire [15:0] host_data_bus_out,
    input wire [1:0] host_data_bus_oe,
    output reg host_chip_select_n,
    output reg [2:0] host_port_addr,
    output wire [15:0] host_data_bus_in,
    output reg host_read_strobe0_n,
    output reg host_read_strobe1_n,
    output reg host_write_strobe0_n,
    output reg host_write_strobe1_n
);
    reg [15:0] drv_r;
    reg drv_en_r;
    // released lines float to the pull-up level
    assign host_data_bus_in[7:0] = host_data_bus_oe[0] ? host_data_bus_out[7:0] : drv_en_r ? drv_r[7:0] : 8'hff;
    assign host_data_bus_in[15:8] = host_data_bus_oe[1] ? host_data_bus_out[15:8] : drv_en_r ? drv_r[15:8] : 8'hff;
    initial begin
        {host_chip_select_n, host_read_strobe0_n, host_read_strobe1_n} = 3'h7;
        {host_write_strobe0_n, host_write_strobe1_n, drv_en_r} = 3'h6;
        host_port_addr = 3'h0;
        drv_r = 16'h0000;
    end
    task xfer(input rd, input [2:0] a, input [15:0] d, input cs, output [15:0] q);
        begin
            @(posedge pclk);
            host_chip_select_n <= ~cs;
            host_port_addr <= a;
            drv_r <= d;
            drv_en_r <= ~rd;
            host_read_strobe0_n <= (iface_type_select == 3'h2) ? 1'b0 : ~rd;
            host_write_strobe0_n <= rd;
            host_read_strobe1_n <= (iface_type_select == 3'h1) ? ~rd : 1'b1;
            host_write_strobe1_n <= (iface_type_select == 3'h1) ? rd : 1'b1;
            repeat (3) @(posedge pclk);
            q = host_data_bus_in;
            // strobes go idle for at least two cycles between accesses
            {host_chip_select_n, host_read_strobe0_n, host_read_strobe1_n} <= 3'h7;
            {host_write_strobe0_n, host_write_strobe1_n, drv_en_r} <= 3'h6;
            @(posedge pclk);
        end
    endtask
endmodule

// ### testbench/hppd_port_tb_top.sv
`timescale 1ns/1ps
`define CHK(a, b) begin compares = compares + 1; if ((a) !== (b)) begin \
    bad_count = bad_count + 1; $display("[FAIL] %0t got %h exp %h", $time, a, b); end end
// --------------------------------
// host port bench
// --------------------------------
module hppd_port_tb_top;
    reg pclk, presetn, psel, penable, pwrite, pol, endn, size;
    reg [7:0] paddr;
    reg [31:0] pwdata, rd;
    reg [2:0] sel;
    reg [15:0] hq;
    reg err;
    integer bad_count, compares;
    wire [31:0] prdata;
    wire [15:0] hin, hout;
    wire [1:0] hoe;
    wire [2:0] ha;
    wire pready, pslverr, cs_n, r0, r1, w0, w1, irq, irq_oe;
    hppd_port i_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .host_chip_select_n(cs_n), .host_port_addr(ha), .host_data_bus_in(hin), .host_data_bus_out(hout),
        .host_data_bus_oe(hoe), .host_read_strobe0_n(r0), .host_read_strobe1_n(r1),
        .host_write_strobe0_n(w0), .host_write_strobe1_n(w1), .host_irq_out(irq), .host_irq_oe(irq_oe),
        .iface_type_select(sel), .irq_polarity_strap(pol), .byte_order_strap(endn), .bus_size_strap(size));
    hppd_host_model i_host (.pclk(pclk), .iface_type_select(sel), .host_data_bus_out(hout),
        .host_data_bus_oe(hoe), .host_chip_select_n(cs_n), .host_port_addr(ha), .host_data_bus_in(hin),
        .host_read_strobe0_n(r0), .host_read_strobe1_n(r1), .host_write_strobe0_n(w0),
        .host_write_strobe1_n(w1));
    initial begin
        pclk = 1'b0;
        forever #10 pclk = ~pclk;
    end
    task complete_run;
        begin
            $display("compares %0d mismatches %0d", compares, bad_count);
            if (bad_count == 0 && compares > 0) $display("STATUS OK");
            else $display("STATUS NOT OK");
            $finish;
        end
    endtask
    task apb(input wr, input [7:0] a, input [31:0] d, output [31:0] q, output e);
        integer n;
        begin
            @(posedge pclk);
            {psel, pwrite, paddr, pwdata} <= {1'b1, wr, a, d};
            @(posedge pclk);
            penable <= 1'b1;
            n = 0;
            do begin
                @(posedge pclk);
                n = n + 1;
            end while (pready !== 1'b1 && n < 50);
            if (pready !== 1'b1) begin
                bad_count = bad_count + 1;
                complete_run;
            end
            q = prdata;
            e = pslverr;
            {psel, penable} <= 2'b00;
            // let the taking edge's updates settle before the caller compares
            @(negedge pclk);
        end
    endtask
    // straps only move while reset is held
    task rst(input [2:0] s, input p, input en, input sz);
        begin
            @(posedge pclk);
            {presetn, sel, pol, endn, size} <= {1'b0, s, p, en, sz};
            repeat (6) @(posedge pclk);
            presetn <= 1'b1;
            repeat (3) @(posedge pclk);
        end
    endtask
    initial begin
        #1000000;
        bad_count = bad_count + 1;
        complete_run;
    end
    initial begin
        {presetn, psel, penable, pwrite, pol, endn, size, sel} = 10'h000;
        {paddr, pwdata, bad_count, compares} = 0;
        repeat (6) @(posedge pclk);
        presetn <= 1'b1;
        repeat (3) @(posedge pclk);
        rst(3'h0, 1'b1, 1'b0, 1'b0);
        apb(0, 8'h00, 0, rd, err);
        `CHK(rd[5:0], 6'h09)
        `CHK(irq, 1'b0)
        apb(1, 8'h08, 32'h1234, rd, err);
        i_host.xfer(1, 3'h1, 0, 1, hq);
        `CHK(hq, 16'h1234)
        i_host.xfer(0, 3'h0, 16'habcd, 1, hq);
        apb(0, 8'h04, 0, rd, err);
        `CHK(rd[15:0], 16'habcd)
        apb(1, 8'h10, 32'h5a5a, rd, err);
        `CHK(irq, 1'b1)
        i_host.xfer(1, 3'h6, 0, 1, hq);
        `CHK(hq, 16'h0002)
        i_host.xfer(1, 3'h2, 0, 1, hq);
        `CHK(hq, 16'h5a5a)
        `CHK(irq, 1'b0)
        i_host.xfer(0, 3'h3, 16'h7777, 0, hq);
        apb(0, 8'h0c, 0, rd, err);
        `CHK(rd[15:0], 16'h0000)
        i_host.xfer(0, 3'h3, 16'h1111, 1, hq);
        apb(0, 8'h0c, 0, rd, err);
        `CHK(rd[15:0], 16'h1111)
        i_host.xfer(0, 3'h4, 16'hffff, 1, hq);
        i_host.xfer(1, 3'h4, 0, 1, hq);
        `CHK(hq, 16'h0000)
        apb(0, 8'h1c, 0, rd, err);
        `CHK({err, rd}, 33'h1_0000_0000)
        rst(3'h2, 1'b0, 1'b1, 1'b1);
        apb(0, 8'h00, 0, rd, err);
        `CHK(rd[5:0], 6'h2e)
        `CHK(irq, 1'b1)
        apb(1, 8'h08, 32'h1234, rd, err);
        i_host.xfer(1, 3'h0, 0, 1, hq);
        `CHK(hq, 16'hff12)
        i_host.xfer(1, 3'h1, 0, 1, hq);
        `CHK(hq, 16'hff34)
        i_host.xfer(0, 3'h2, 16'h0022, 1, hq);
        i_host.xfer(0, 3'h3, 16'h0011, 1, hq);
        apb(0, 8'h0c, 0, rd, err);
        `CHK(rd[15:0], 16'h1122)
        apb(1, 8'h14, 32'h1, rd, err);
        `CHK(irq, 1'b0)
        i_host.xfer(1, 3'h4, 0, 1, hq);
        `CHK(hq, 16'hff01)
        i_host.xfer(1, 3'h5, 0, 1, hq);
        `CHK(hq, 16'hff00)
        `CHK(irq, 1'b1)
        rst(3'h1, 1'b1, 1'b1, 1'b0);
        apb(0, 8'h00, 0, rd, err);
        `CHK(rd[5:0], 6'h1b)
        i_host.xfer(0, 3'h0, 16'habcd, 1, hq);
        apb(0, 8'h04, 0, rd, err);
        `CHK(rd[15:0], 16'hcdab)
        apb(1, 8'h08, 32'h1234, rd, err);
        i_host.xfer(1, 3'h0, 0, 1, hq);
        `CHK(hq, 16'h3412)
        complete_run;
    end
endmodule
bind hppd_port hppd_port_checker i_chk (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .prdata(prdata), .host_chip_select_n(host_chip_select_n),
    .host_data_bus_oe(host_data_bus_oe), .host_read_strobe0_n(host_read_strobe0_n),
    .host_read_strobe1_n(host_read_strobe1_n), .host_write_strobe0_n(host_write_strobe0_n),
    .host_irq_out(host_irq_out), .host_irq_oe(host_irq_oe), .iface_type_select(iface_type_select),
    .irq_polarity_strap(irq_polarity_strap), .byte_order_strap(byte_order_strap),
    .bus_size_strap(bus_size_strap));
